/* rtl/acl4_matcher.sv */
// ipv4 rule entry matcher with axi4-lite configuration port
// assumes parsed headers arrive on the core clock from the ingress parser
`timescale 1ns/1ps
module acl4_matcher
  import acl4_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hdr_valid,
  input wire acl4_hdr_t hdr,
  output logic res_valid,
  output acl4_result_t res,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // axi4-lite write path
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] ctrl;
  logic [31:0] vals;
  logic [31:0] src_addr_match;
  logic [31:0] src_netmask;
  logic [31:0] dst_addr_match;
  logic [31:0] dst_netmask;
  logic [31:0] hit_count;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held && w_held;
  wire wr_hit_ctrl = (aw_addr == ACL4_REG_CTRL);
  wire wr_known = wr_hit_ctrl || (aw_addr == ACL4_REG_VALS) ||
                  (aw_addr == ACL4_REG_SRC_ADDR) || (aw_addr == ACL4_REG_SRC_MASK) ||
                  (aw_addr == ACL4_REG_DST_ADDR) || (aw_addr == ACL4_REG_DST_MASK) ||
                  (aw_addr == ACL4_REG_HITS);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACL4_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? ACL4_RESP_OKAY : ACL4_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= ACL4_CTRL_RST;
      vals <= 32'h0000_0000;
      src_addr_match <= 32'h0000_0000;
      src_netmask <= 32'h0000_0000;
      dst_addr_match <= 32'h0000_0000;
      dst_netmask <= 32'h0000_0000;
    end else if (wr_go) begin
      if (wr_hit_ctrl) begin
        ctrl <= merge(ctrl, w_data, wmask) & ACL4_CTRL_MASK;
      end
      if (aw_addr == ACL4_REG_VALS) begin
        vals <= merge(vals, w_data, wmask) & 32'h00FF_FFFF;
      end
      if (aw_addr == ACL4_REG_SRC_ADDR) begin
        src_addr_match <= merge(src_addr_match, w_data, wmask);
      end
      if (aw_addr == ACL4_REG_SRC_MASK) begin
        src_netmask <= merge(src_netmask, w_data, wmask);
      end
      if (aw_addr == ACL4_REG_DST_ADDR) begin
        dst_addr_match <= merge(dst_addr_match, w_data, wmask);
      end
      if (aw_addr == ACL4_REG_DST_MASK) begin
        dst_netmask <= merge(dst_netmask, w_data, wmask);
      end
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  wire entry_ipv4 = ctrl[ACL4_F_IPV4];
  wire acl4_proto_mode_t pmode = acl4_proto_mode_t'(ctrl[ACL4_F_PROTO +: 3]);
  wire acl4_qual_t ttl_q = acl4_qual_t'(ctrl[ACL4_F_TTL +: 2]);
  wire acl4_qual_t frag_q = acl4_qual_t'(ctrl[ACL4_F_FRAG +: 2]);
  wire acl4_qual_t opt_q = acl4_qual_t'(ctrl[ACL4_F_OPT +: 2]);
  wire acl4_addr_mode_t src_mode = acl4_addr_mode_t'(ctrl[ACL4_F_SRC +: 2]);
  wire acl4_addr_mode_t dst_mode = acl4_addr_mode_t'(ctrl[ACL4_F_DST +: 2]);
  wire itype_spec = ctrl[ACL4_F_ITYPE];
  wire icode_spec = ctrl[ACL4_F_ICODE];
  wire [7:0] cfg_proto = vals[ACL4_V_PROTO +: 8];
  wire [7:0] cfg_itype = vals[ACL4_V_ITYPE +: 8];
  wire [7:0] cfg_icode = vals[ACL4_V_ICODE +: 8];

  // ****************************************
  // criteria
  // ****************************************
  wire proto_ok = (pmode == ACL4_P_ANY) ? 1'b1 :
                  (pmode == ACL4_P_SPEC) ? (hdr.proto == cfg_proto) :
                  (pmode == ACL4_P_ICMP) ? (hdr.proto == ACL4_PROTO_ICMP) :
                  (pmode == ACL4_P_UDP) ? (hdr.proto == ACL4_PROTO_UDP) :
                  (pmode == ACL4_P_TCP) ? (hdr.proto == ACL4_PROTO_TCP) : 1'b0;

  wire ttl_pos = (hdr.ttl != 8'h00);
  wire is_frag = hdr.more_frag || (hdr.frag_off != 13'h0000);

  // a qualifier is yes/no against one header property, or any
  function automatic logic qual_pass(input acl4_qual_t q, input logic prop);
    qual_pass = (q == ACL4_Q_ANY) ? 1'b1 :
                (q == ACL4_Q_NO) ? !prop :
                (q == ACL4_Q_YES) ? prop : 1'b0;
  endfunction : qual_pass

  wire ttl_ok = qual_pass(ttl_q, ttl_pos);
  wire frag_ok = qual_pass(frag_q, is_frag);
  wire opt_ok = qual_pass(opt_q, hdr.has_opts);
  wire qual_ok = ttl_ok && frag_ok && opt_ok;

  logic src_ok;
  logic dst_ok;
  acl4_addr_cmp u_src_cmp (
    .mode(src_mode),
    .cfg_addr(src_addr_match),
    .cfg_mask(src_netmask),
    .frame_addr(hdr.src_addr),
    .ok(src_ok)
  );
  acl4_addr_cmp u_dst_cmp (
    .mode(dst_mode),
    .cfg_addr(dst_addr_match),
    .cfg_mask(dst_netmask),
    .frame_addr(hdr.dst_addr),
    .ok(dst_ok)
  );
  wire addr_ok = src_ok && dst_ok;

  // icmp sub-criteria only count when the entry selects icmp
  wire icmp_sel = (pmode == ACL4_P_ICMP);
  wire itype_ok = !itype_spec || (hdr.icmp_type == cfg_itype);
  wire icode_ok = !icode_spec || (hdr.icmp_code == cfg_icode);
  wire icmp_ok = !icmp_sel || (itype_ok && icode_ok);

  // non-ipv4 frames and non-ipv4 entries never reach a hit here
  wire all_ok = entry_ipv4 && hdr.ipv4 &&
                proto_ok && qual_ok && addr_ok && icmp_ok;

  // ****************************************
  // registered result, one cycle after hdr_valid
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_valid <= 1'b0;
      res <= '0;
    end else begin
      res_valid <= hdr_valid;
      if (hdr_valid) begin
        res <= '{hit: all_ok, proto_ok: proto_ok, qual_ok: qual_ok,
                 addr_ok: addr_ok, icmp_ok: icmp_ok};
      end
    end
  end

  // hit counter: a clear loads 1 if a hit lands in the write cycle, so that hit is kept
  wire hit_now = res_valid && res.hit;
  wire hits_clr = wr_go && (aw_addr == ACL4_REG_HITS);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hit_count <= 32'h0000_0000;
    end else if (hits_clr) begin
      hit_count <= hit_now ? 32'h0000_0001 : 32'h0000_0000;
    end else if (hit_now) begin
      hit_count <= hit_count + 32'h0000_0001;
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [31:0] stat_word = {27'h0000000, res.icmp_ok, res.addr_ok, res.qual_ok,
                           res.proto_ok, res.hit};
  wire rd_known = (s_axi_araddr == ACL4_REG_CTRL) || (s_axi_araddr == ACL4_REG_VALS) ||
                  (s_axi_araddr == ACL4_REG_SRC_ADDR) || (s_axi_araddr == ACL4_REG_SRC_MASK) ||
                  (s_axi_araddr == ACL4_REG_DST_ADDR) || (s_axi_araddr == ACL4_REG_DST_MASK) ||
                  (s_axi_araddr == ACL4_REG_STAT) || (s_axi_araddr == ACL4_REG_HITS);
  wire [31:0] rd_word =
    (s_axi_araddr == ACL4_REG_CTRL) ? ctrl :
    (s_axi_araddr == ACL4_REG_VALS) ? vals :
    (s_axi_araddr == ACL4_REG_SRC_ADDR) ? src_addr_match :
    (s_axi_araddr == ACL4_REG_SRC_MASK) ? src_netmask :
    (s_axi_araddr == ACL4_REG_DST_ADDR) ? dst_addr_match :
    (s_axi_araddr == ACL4_REG_DST_MASK) ? dst_netmask :
    (s_axi_araddr == ACL4_REG_STAT) ? stat_word :
    (s_axi_araddr == ACL4_REG_HITS) ? hit_count : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ACL4_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? ACL4_RESP_OKAY : ACL4_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_hdr_in;
    hdr_valid;
  endsequence

  a_ipv4_gate_only: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (!entry_ipv4 || !hdr.ipv4) |=> !res.hit)
    else $error("hit on a non-ipv4 frame or entry");
  a_spec_proto_eq: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (pmode == ACL4_P_SPEC) && (hdr.proto != cfg_proto) |=> !res.proto_ok)
    else $error("specific protocol passed a different value");
  a_icmp_proto_sel: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (pmode == ACL4_P_ICMP) |=> res.proto_ok == $past(hdr.proto == 8'h01))
    else $error("icmp selection wrong on protocol byte");
  a_ttl_zero_rej: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (ttl_q == ACL4_Q_NO) && ttl_pos |=> !res.qual_ok && !res.hit)
    else $error("ttl zero qualifier passed a live frame");
  a_ttl_live_need: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (ttl_q == ACL4_Q_YES) && !ttl_pos |=> !res.hit)
    else $error("ttl non-zero qualifier passed a dead frame");
  a_frag_no_rej: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (frag_q == ACL4_Q_NO) && is_frag |=> !res.qual_ok)
    else $error("fragment no passed a fragment");
  a_opt_yes_need: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (opt_q == ACL4_Q_YES) && !hdr.has_opts |=> !res.qual_ok)
    else $error("option yes passed a frame without options");
  a_src_net_mask: assert property (@(posedge core_clk) disable iff (srst)
    (src_mode == ACL4_A_NET) |->
      src_ok == ((hdr.src_addr & src_netmask) == (src_addr_match & src_netmask)))
    else $error("masked source compare wrong");
  a_icmp_type_eq: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 icmp_sel && itype_spec && (hdr.icmp_type != cfg_itype) |=> !res.icmp_ok)
    else $error("icmp type filter passed a wrong type");
  a_hit_all_and: assert property (@(posedge core_clk) disable iff (srst)
    res_valid && res.hit |-> res.proto_ok && res.qual_ok && res.addr_ok && res.icmp_ok)
    else $error("hit without every criterion");
  // the remaining criteria except udp/tcp selection, and the one-cycle verdict timing
  a_proto_any_pass: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (pmode == ACL4_P_ANY) |=> res.proto_ok)
    else $error("protocol any rejected a frame");
  a_frag_yes_need: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (frag_q == ACL4_Q_YES) && !is_frag |=> !res.qual_ok)
    else $error("fragment yes passed a whole frame");
  a_opt_no_rej: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (opt_q == ACL4_Q_NO) && hdr.has_opts |=> !res.qual_ok)
    else $error("option no passed a frame with options");
  a_qual_any_pass: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 (ttl_q == ACL4_Q_ANY) && (frag_q == ACL4_Q_ANY) && (opt_q == ACL4_Q_ANY)
      |=> res.qual_ok)
    else $error("qualifiers set to any rejected a frame");
  a_src_any_pass: assert property (@(posedge core_clk) disable iff (srst)
    (src_mode == ACL4_A_ANY) |-> src_ok)
    else $error("source any rejected an address");
  a_src_host_eq: assert property (@(posedge core_clk) disable iff (srst)
    (src_mode == ACL4_A_HOST) |-> src_ok == (hdr.src_addr == src_addr_match))
    else $error("source host compare wrong");
  a_dst_any_pass: assert property (@(posedge core_clk) disable iff (srst)
    (dst_mode == ACL4_A_ANY) |-> dst_ok)
    else $error("destination any rejected an address");
  a_dst_host_eq: assert property (@(posedge core_clk) disable iff (srst)
    (dst_mode == ACL4_A_HOST) |-> dst_ok == (hdr.dst_addr == dst_addr_match))
    else $error("destination host compare wrong");
  a_dst_net_mask: assert property (@(posedge core_clk) disable iff (srst)
    (dst_mode == ACL4_A_NET) |->
      dst_ok == ((hdr.dst_addr & dst_netmask) == (dst_addr_match & dst_netmask)))
    else $error("masked destination compare wrong");
  a_icmp_type_any: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 icmp_sel && !itype_spec && (!icode_spec || hdr.icmp_code == cfg_icode)
      |=> res.icmp_ok)
    else $error("icmp type any rejected a frame");
  a_icmp_code_any: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 icmp_sel && !icode_spec && (!itype_spec || hdr.icmp_type == cfg_itype)
      |=> res.icmp_ok)
    else $error("icmp code any rejected a frame");
  a_icmp_code_eq: assert property (@(posedge core_clk) disable iff (srst)
    s_hdr_in ##0 icmp_sel && icode_spec && (hdr.icmp_code != cfg_icode) |=> !res.icmp_ok)
    else $error("icmp code filter passed a wrong code");
  a_res_follows_hdr: assert property (@(posedge core_clk) disable iff (srst)
    res_valid == $past(hdr_valid))
    else $error("verdict strobe not one cycle after the header");

endmodule : acl4_matcher

/* rtl/acl4_pkg.sv */
// constants, field layouts and carrier types of the ipv4 rule entry matcher
// assumes a single core clock; the parser delivers one header per valid cycle
// Behaviour
// - ipv4 criteria apply only to ipv4 entries
// - protocol any ignores protocol field
// - specific protocol must equal configured byte
// - icmp/udp/tcp select protocol, enable subcriteria (here only icmp has subcriteria: type and code)
// - ttl zero rejects ttl above zero
// - ttl non-zero needs ttl above zero
// - fragment no excludes mf or offset
// - fragment yes needs mf or offset
// - option no excludes frames with options
// - option yes needs options present
// - any setting ignores ttl/fragment/option
// - source any ignores source address
// - source host needs exact address
// - source network compares under mask
// - destination any ignores destination address
// - destination host needs exact address
// - destination network compares under mask
// - icmp type any ignores type byte
// - icmp type specific needs equal byte
// - icmp code any ignores code byte
// - icmp code specific needs equal byte
package acl4_pkg;

  // ****************************************
  // register map (axi4-lite byte addresses)
  // ****************************************
  localparam logic [7:0] ACL4_REG_CTRL = 8'h00;
  localparam logic [7:0] ACL4_REG_VALS = 8'h04;
  localparam logic [7:0] ACL4_REG_SRC_ADDR = 8'h08;
  localparam logic [7:0] ACL4_REG_SRC_MASK = 8'h0C;
  localparam logic [7:0] ACL4_REG_DST_ADDR = 8'h10;
  localparam logic [7:0] ACL4_REG_DST_MASK = 8'h14;
  localparam logic [7:0] ACL4_REG_STAT = 8'h18;
  localparam logic [7:0] ACL4_REG_HITS = 8'h1C;

  // ****************************************
  // ctrl field positions
  // ****************************************
  localparam int ACL4_F_IPV4 = 0;
  localparam int ACL4_F_PROTO = 1;
  localparam int ACL4_F_TTL = 4;
  localparam int ACL4_F_FRAG = 6;
  localparam int ACL4_F_OPT = 8;
  localparam int ACL4_F_SRC = 10;
  localparam int ACL4_F_DST = 12;
  localparam int ACL4_F_ITYPE = 14;
  localparam int ACL4_F_ICODE = 15;
  localparam logic [31:0] ACL4_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ACL4_CTRL_MASK = 32'h0000_FFFF;
  // vals: proto [7:0], icmp type [15:8], icmp code [23:16]
  localparam int ACL4_V_PROTO = 0;
  localparam int ACL4_V_ITYPE = 8;
  localparam int ACL4_V_ICODE = 16;

  localparam logic [7:0] ACL4_PROTO_ICMP = 8'h01;
  localparam logic [7:0] ACL4_PROTO_TCP = 8'h06;
  localparam logic [7:0] ACL4_PROTO_UDP = 8'h11;
  localparam logic [1:0] ACL4_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACL4_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ACL4_P_ANY = 3'h0, ACL4_P_SPEC = 3'h1, ACL4_P_ICMP = 3'h2,
    ACL4_P_UDP = 3'h3, ACL4_P_TCP = 3'h4
  } acl4_proto_mode_t;

  // three-way qualifier: 0 = any, 1 = no/zero, 2 = yes/non-zero
  typedef enum logic [1:0] {
    ACL4_Q_ANY = 2'h0, ACL4_Q_NO = 2'h1, ACL4_Q_YES = 2'h2
  } acl4_qual_t;

  typedef enum logic [1:0] {
    ACL4_A_ANY = 2'h0, ACL4_A_HOST = 2'h1, ACL4_A_NET = 2'h2
  } acl4_addr_mode_t;

  typedef struct packed {
    logic ipv4;
    logic [7:0] proto;
    logic [7:0] ttl;
    logic more_frag;
    logic [12:0] frag_off;
    logic has_opts;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [7:0] icmp_type;
    logic [7:0] icmp_code;
  } acl4_hdr_t;

  typedef struct packed {
    logic hit;
    logic proto_ok;
    logic qual_ok;
    logic addr_ok;
    logic icmp_ok;
  } acl4_result_t;

endpackage : acl4_pkg

/* rtl/acl4_addr_cmp.sv */
// one address filter: any, host or masked network
// assumes configuration is stable while frames are judged
`timescale 1ns/1ps
module acl4_addr_cmp
  import acl4_pkg::*;
(
  input wire acl4_addr_mode_t mode,
  input wire logic [31:0] cfg_addr,
  input wire logic [31:0] cfg_mask,
  input wire logic [31:0] frame_addr,
  output logic ok
);
  wire host_eq = (frame_addr == cfg_addr);
  wire net_eq = ((frame_addr & cfg_mask) == (cfg_addr & cfg_mask));

  // unknown mode codes never match, so a bad write cannot open the filter
  assign ok = (mode == ACL4_A_ANY) ? 1'b1 :
              (mode == ACL4_A_HOST) ? host_eq :
              (mode == ACL4_A_NET) ? net_eq : 1'b0;
endmodule : acl4_addr_cmp

/* sim/acl4_ingress_model.sv */
// ingress parser stand-in: presents one parsed header and collects the verdict
// assumes the matcher answers exactly one cycle after each header cycle
`timescale 1ns/1ps
module acl4_ingress_model
  import acl4_pkg::*;
(
  input wire logic core_clk,
  output logic hdr_valid,
  output acl4_hdr_t hdr,
  input wire logic res_valid,
  input wire acl4_result_t res
);
  initial begin
    hdr_valid = 1'b0;
    hdr = '0;
  end

  // released header is inverted so stale fields can never help a match
  task automatic send(input acl4_hdr_t h, output acl4_result_t r, output logic seen);
    @(posedge core_clk);
    hdr_valid <= 1'b1;
    hdr <= h;
    @(posedge core_clk);
    hdr_valid <= 1'b0;
    hdr <= ~h;
    @(posedge core_clk);
    r = res;
    seen = res_valid;
  endtask : send
endmodule : acl4_ingress_model

/* sim/acl4_matcher_test.sv */
// self-checking bench for the ipv4 rule entry matcher
// assumes the ingress model drives headers and axi4-lite writes configure the entry
`timescale 1ns/1ps
module acl4_matcher_test
  import acl4_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hdr_valid;
  acl4_hdr_t hdr;
  logic res_valid;
  acl4_result_t res;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int error_cnt = 0;
  int samples_checked = 0;
  acl4_hdr_t b, h;
  logic [7:0] pv [3] = '{ACL4_PROTO_ICMP, ACL4_PROTO_UDP, ACL4_PROTO_TCP};
  logic [31:0] fa [3] = '{32'hC0A8_0100, 32'hC0A8_01FF, 32'hC0A8_0000};
  logic [2:0] ex [4] = '{3'b111, 3'b001, 3'b011, 3'b000};
  logic exp_hit;

  always #2.5 core_clk = ~core_clk;

  acl4_matcher u_dut (.core_clk, .srst, .hdr_valid, .hdr, .res_valid, .res,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  acl4_ingress_model u_ing (.core_clk, .hdr_valid, .hdr, .res_valid, .res);

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic cmp(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : cmp

  // no local limit: a hung handshake is ended by the watchdog
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'(s_axi_bresp), 32'(e));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e,
                    input logic [31:0] m);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp("rresp", 32'(s_axi_rresp), 32'(e));
    cmp("rdata", s_axi_rdata & m, d);
  endtask : rd

  task automatic fr(input acl4_hdr_t f, input logic e);
    acl4_result_t r;
    logic v;
    u_ing.send(f, r, v);
    cmp("res_valid", 32'(v), 32'h1);
    cmp("hit", 32'(r.hit), 32'(e));
  endtask : fr

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    b = '0;
    b.ipv4 = 1'b1;
    b.proto = ACL4_PROTO_TCP;
    b.ttl = 8'h40;
    b.src_addr = 32'h0A00_0001;
    b.dst_addr = 32'hC0A8_0102;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rd(ACL4_REG_CTRL, ACL4_CTRL_RST, ACL4_RESP_OKAY, 32'hFFFF_FFFF);
    rd(ACL4_REG_HITS, 32'h0, ACL4_RESP_OKAY, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, ACL4_RESP_SLVERR, 32'hFFFF_FFFF);
    wr(8'h20, 32'h1, ACL4_RESP_SLVERR);
    wr(ACL4_REG_STAT, 32'h1, ACL4_RESP_SLVERR);
    wr(ACL4_REG_CTRL, 32'hFFFF_FFFF, ACL4_RESP_OKAY);
    rd(ACL4_REG_CTRL, ACL4_CTRL_MASK, ACL4_RESP_OKAY, 32'hFFFF_FFFF);
    wr(ACL4_REG_CTRL, 32'h1, ACL4_RESP_OKAY);
    fr(b, 1'b1);
    h = b;
    h.ipv4 = 1'b0;
    fr(h, 1'b0);
    wr(ACL4_REG_VALS, 32'h0000_0011, ACL4_RESP_OKAY);
    // codes 5 to 7 are unused protocol modes and must never match
    for (int i = 0; i < 8; i++) begin
      wr(ACL4_REG_CTRL, 32'h1 | (32'(i) << ACL4_F_PROTO), ACL4_RESP_OKAY);
      for (int j = 0; j < 3; j++) begin
        h = b;
        h.proto = pv[j];
        fr(h, i == 0 || (i == 1 && j == 1) || i == j + 2);
      end
    end
    // extremes of the specific protocol value
    wr(ACL4_REG_CTRL, 32'h1 | (32'(ACL4_P_SPEC) << ACL4_F_PROTO), ACL4_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      wr(ACL4_REG_VALS, k ? 32'h0000_00FF : 32'h0, ACL4_RESP_OKAY);
      h = b;
      h.proto = k ? 8'hFF : 8'h00;
      fr(h, 1'b1);
      h.proto = k ? 8'hFE : 8'h01;
      fr(h, 1'b0);
    end
    // k picks ttl, fragment or option; c = 0 means the property is absent
    for (int k = 0; k < 3; k++) begin
      for (int q = 0; q < 4; q++) begin
        wr(ACL4_REG_CTRL, 32'h1 | (32'(q) << (ACL4_F_TTL + 2 * k)), ACL4_RESP_OKAY);
        for (int c = 0; c < 3; c++) begin
          h = b;
          if (k == 0) h.ttl = (c == 0) ? 8'h00 : (c == 1) ? 8'h01 : 8'hFF;
          if (k == 1) h.more_frag = (c == 1);
          if (k == 1) h.frag_off = (c == 2) ? 13'h0001 : 13'h0000;
          if (k == 2) h.has_opts = (c != 0);
          // qualifier code 3 is unused and must never match
          exp_hit = q == 0 || (q < 3 && (q == 1) == (c == 0));
          if (k == 0) fr(h, exp_hit);
          if (k == 1) fr(h, exp_hit);
          if (k == 2) fr(h, exp_hit);
        end
      end
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'(ACL4_REG_SRC_ADDR + 8 * s), 32'hC0A8_0100, ACL4_RESP_OKAY);
      wr(8'(ACL4_REG_SRC_MASK + 8 * s), 32'hFFFF_FF00, ACL4_RESP_OKAY);
      for (int m = 0; m < 4; m++) begin
        wr(ACL4_REG_CTRL, 32'h1 | (32'(m) << (ACL4_F_SRC + 2 * s)), ACL4_RESP_OKAY);
        for (int c = 0; c < 3; c++) begin
          h = b;
          if (s == 0) h.src_addr = fa[c];
          else h.dst_addr = fa[c];
          fr(h, ex[m][c]);
        end
      end
    end
    wr(ACL4_REG_VALS, 32'h0002_0800, ACL4_RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      wr(ACL4_REG_CTRL, 32'h1 | (32'(ACL4_P_ICMP) << ACL4_F_PROTO) | (32'(m) << ACL4_F_ITYPE),
         ACL4_RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
        h = b;
        h.proto = ACL4_PROTO_ICMP;
        h.icmp_type = {7'h04, c[0]};
        h.icmp_code = {7'h01, c[1]};
        fr(h, (!m[0] || !c[0]) && (!m[1] || !c[1]));
      end
    end
    // several criteria at once, then the counter and status views
    wr(ACL4_REG_CTRL, 32'h1 | (32'(ACL4_P_TCP) << ACL4_F_PROTO) |
       (32'(ACL4_Q_YES) << ACL4_F_TTL) | (32'(ACL4_Q_NO) << ACL4_F_OPT), ACL4_RESP_OKAY);
    wr(ACL4_REG_HITS, 32'h0, ACL4_RESP_OKAY);
    fr(b, 1'b1);
    h = b;
    h.has_opts = 1'b1;
    fr(h, 1'b0);
    h = b;
    h.ttl = 8'h00;
    fr(h, 1'b0);
    fr(b, 1'b1);
    rd(ACL4_REG_HITS, 32'h2, ACL4_RESP_OKAY, 32'hFFFF_FFFF);
    rd(ACL4_REG_STAT, 32'h1F, ACL4_RESP_OKAY, 32'hFFFF_FFFF);
    end_of_test();
  end
endmodule : acl4_matcher_test
